// File: verilog/fce_fault_classify_escalate.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fce_cfg.svh"
module fce_fault_classify_escalate (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            resetn_i,
    // Fault reports and execution context
    input  wire fce_pkg::fce_fault_s fault_i,
    input  wire fce_pkg::fce_ctx_s   ctx_i,
    // Towards prioritiser and pipeline
    output var  fce_pkg::fce_take_s  take_o,
    output logic                 lockup_o,
    // AHB-Lite slave
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic            hready_i,
    input  wire logic [31:0]     hwdata_i,
    output logic [31:0]          hrdata_o,
    output logic                 hreadyout_o,
    output logic                 hresp_o
);
    import fce_pkg::*;

    // ------------------------------------------------
    // Classification
    // ------------------------------------------------
    logic [31:0] hcause_q, mcause_q, bcause_q, ucause_q;
    logic [31:0] maddr_q, baddr_q, enable_q, prio_q;
    logic        lock_q;
    fce_take_s   take_q;

    wire fce_kind_e k     = fault_i.kind;
    wire logic      f_vld = fault_i.valid & ~lock_q;
    wire logic is_bus = (k == FK_BUS_PUSH) | (k == FK_BUS_POP)
                      | (k == FK_BUS_FETCH) | (k == FK_BUS_EXACT)
                      | (k == FK_BUS_DEFER);
    wire logic is_mm  = (k == FK_MM_XN) | (k == FK_MM_DATA);
    // Vector read error is hard from the start
    wire fce_class_e cls = (k == FK_VECT) ? FC_HARD :
                           is_bus ? FC_BUS :
                           is_mm  ? FC_MM : FC_USAGE;

    // Per-class priority and enable; hard fault has none
    wire logic [7:0] prio_sel =
        (cls == FC_MM)  ? prio_q[7:0] :
        (cls == FC_BUS) ? prio_q[15:8] : prio_q[23:16];
    wire logic en_sel =
        (cls == FC_MM)  ? enable_q[`FCE_EN_MM] :
        (cls == FC_BUS) ? enable_q[`FCE_EN_BUS] :
        enable_q[`FCE_EN_USG];

    // ------------------------------------------------
    // Escalation
    // ------------------------------------------------
    wire logic same_kind  = ctx_i.in_handler & (ctx_i.active == cls);
    wire logic low_prio   = prio_sel >= ctx_i.cur_prio;
    wire logic hnd_low    = ctx_i.in_handler & low_prio;
    wire logic push_exempt = (k == FK_BUS_PUSH) & ctx_i.bus_entry;
    wire logic esc = (cls != FC_HARD) & ~push_exempt
                   & (~en_sel | same_kind | hnd_low);
    wire logic to_hard = (cls == FC_HARD) | esc;
    wire logic in_hf   = ctx_i.active == FC_HARD;
    wire logic lock_hit = f_vld & to_hard & in_hf;
    // Hard fault only yields to reset, NMI and itself
    wire logic hf_pre = ~in_hf & (ctx_i.active != FC_NMI);
    // Configurable fault enters only above current level, outside hard fault and NMI
    wire logic cfg_pre = ~low_prio & ~in_hf & (ctx_i.active != FC_NMI);
    wire fce_class_e fin_cls = to_hard ? FC_HARD : cls;

    // ------------------------------------------------
    // Cause flag set vectors
    // ------------------------------------------------
    logic [31:0] hset, mset, bset, uset;
    always_comb begin
        hset = 32'h0000_0000;
        mset = 32'h0000_0000;
        bset = 32'h0000_0000;
        uset = 32'h0000_0000;
        if (f_vld) begin
            hset[`FCE_HF_VECT]  = (k == FK_VECT);
            hset[`FCE_HF_ESC]   = esc;
            bset[`FCE_BF_PUSH]  = (k == FK_BUS_PUSH);
            bset[`FCE_BF_POP]   = (k == FK_BUS_POP);
            bset[`FCE_BF_FETCH] = (k == FK_BUS_FETCH);
            bset[`FCE_BF_EXACT] = (k == FK_BUS_EXACT);
            bset[`FCE_BF_DEFER] = (k == FK_BUS_DEFER);
            bset[`FCE_BF_AVALID] = (k == FK_BUS_EXACT);
            mset[`FCE_MM_IACC]  = (k == FK_MM_XN);
            mset[`FCE_MM_DACC]  = (k == FK_MM_DATA);
            mset[`FCE_MM_AVALID] = (k == FK_MM_DATA);
            uset[`FCE_UF_NO_COPROC_FLAG]  = (k == FK_NO_COPROC_FLAG);
            uset[`FCE_UF_UNDEF] = (k == FK_UNDEF);
            uset[`FCE_UF_ISA]   = (k == FK_ISA);
            uset[`FCE_UF_RET]   = (k == FK_RETURN);
            uset[`FCE_UF_UNAL]  = (k == FK_UNALIGN);
            uset[`FCE_UF_DIV0]  = (k == FK_DIV0);
        end
    end

    // ------------------------------------------------
    // AHB-Lite slave, one wait state per transfer
    // ------------------------------------------------
    logic [7:0] a_off_q;
    logic       a_wr_q, busy_q, rdy_q;
    logic [31:0] rdata_q;

    wire logic accept = hsel_i & htrans_i[1] & hready_i;
    wire logic wr_now = busy_q & a_wr_q;
    wire logic w_hc = wr_now & (a_off_q == `FCE_OFF_HCAUSE);
    wire logic w_mc = wr_now & (a_off_q == `FCE_OFF_MCAUSE);
    wire logic w_bc = wr_now & (a_off_q == `FCE_OFF_BCAUSE);
    wire logic w_uc = wr_now & (a_off_q == `FCE_OFF_UCAUSE);
    wire logic w_en = wr_now & (a_off_q == `FCE_OFF_ENABLE);
    wire logic w_pr = wr_now & (a_off_q == `FCE_OFF_PRIO);

    logic [31:0] rd_mux;
    always_comb begin
        if (a_off_q == `FCE_OFF_HCAUSE) begin
            rd_mux = hcause_q;
        end else if (a_off_q == `FCE_OFF_MCAUSE) begin
            rd_mux = mcause_q;
        end else if (a_off_q == `FCE_OFF_BCAUSE) begin
            rd_mux = bcause_q;
        end else if (a_off_q == `FCE_OFF_UCAUSE) begin
            rd_mux = ucause_q;
        end else if (a_off_q == `FCE_OFF_MADDR) begin
            rd_mux = maddr_q;
        end else if (a_off_q == `FCE_OFF_BADDR) begin
            rd_mux = baddr_q;
        end else if (a_off_q == `FCE_OFF_ENABLE) begin
            rd_mux = enable_q;
        end else if (a_off_q == `FCE_OFF_PRIO) begin
            rd_mux = prio_q;
        end else if (a_off_q == `FCE_OFF_STATUS) begin
            rd_mux = {31'h0000_0000, lock_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_off_q <= 8'h00;
            a_wr_q  <= 1'b0;
            busy_q  <= 1'b0;
            rdy_q   <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (accept) begin
            a_off_q <= {haddr_i[7:2], 2'b00};
            a_wr_q  <= hwrite_i;
            busy_q  <= 1'b1;
            rdy_q   <= 1'b0;
        end else if (busy_q) begin
            // Reads sample after any earlier write has landed
            rdata_q <= a_wr_q ? 32'h0000_0000 : rd_mux;
            busy_q  <= 1'b0;
            rdy_q   <= 1'b1;
        end
    end

    // ------------------------------------------------
    // Cause registers: set beats write-one clear
    // ------------------------------------------------
    wire logic [31:0] hclr = w_hc ? hwdata_i : 32'h0000_0000;
    wire logic [31:0] mclr = w_mc ? hwdata_i : 32'h0000_0000;
    wire logic [31:0] bclr = w_bc ? hwdata_i : 32'h0000_0000;
    wire logic [31:0] uclr = w_uc ? hwdata_i : 32'h0000_0000;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hcause_q <= 32'h0000_0000;
            mcause_q <= 32'h0000_0000;
            bcause_q <= 32'h0000_0000;
            ucause_q <= 32'h0000_0000;
        end else begin
            hcause_q <= (hcause_q & ~hclr) | hset;
            mcause_q <= (mcause_q & ~mclr) | mset;
            bcause_q <= (bcause_q & ~bclr) | bset;
            ucause_q <= (ucause_q & ~uclr) | uset;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            maddr_q  <= 32'h0000_0000;
            baddr_q  <= 32'h0000_0000;
            enable_q <= `FCE_ENABLE_RST;
            prio_q   <= `FCE_PRIO_RST;
        end else begin
            if (mset[`FCE_MM_AVALID]) begin
                maddr_q <= fault_i.addr;
            end
            if (bset[`FCE_BF_AVALID]) begin
                baddr_q <= fault_i.addr;
            end
            if (w_en) begin
                enable_q <= hwdata_i & 32'h0000_0007;
            end
            if (w_pr) begin
                prio_q <= hwdata_i & 32'h00FF_FFFF;
            end
        end
    end

    // ------------------------------------------------
    // Handler request and lockup
    // ------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            take_q <= '0;
            lock_q <= 1'b0;
        end else begin
            // Lockup is sticky; only reset leaves it
            lock_q <= lock_q | lock_hit;
            take_q.valid     <= f_vld & ~lock_hit;
            take_q.cls       <= fin_cls;
            take_q.escalated <= esc;
            take_q.preempt   <= to_hard ? hf_pre : cfg_pre;
        end
    end

    assign take_o      = take_q;
    assign lockup_o    = lock_q;
    assign hrdata_o    = rdata_q;
    assign hreadyout_o = rdy_q;
    assign hresp_o     = 1'b0;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_vect_hard;
        f_vld && k == FK_VECT && !in_hf |=> take_o.valid && take_o.cls == FC_HARD
            && hcause_q[`FCE_HF_VECT];
    endproperty
    a_vect_hard: assert property (p_vect_hard) else $error("vector error not hard");

    property p_disabled_esc;
        f_vld && cls != FC_HARD && !en_sel && !push_exempt && !in_hf
            |=> take_o.cls == FC_HARD && take_o.escalated && hcause_q[`FCE_HF_ESC];
    endproperty
    a_disabled_esc: assert property (p_disabled_esc) else $error("disabled fault kept class");

    property p_low_prio_esc;
        f_vld && cls != FC_HARD && ctx_i.in_handler && prio_sel >= ctx_i.cur_prio
            && !push_exempt && !in_hf |=> take_o.cls == FC_HARD;
    endproperty
    a_low_prio_esc: assert property (p_low_prio_esc) else $error("low priority fault not escalated");

    property p_push_exempt;
        f_vld && k == FK_BUS_PUSH && ctx_i.bus_entry
            |=> take_o.cls == FC_BUS && !take_o.escalated && bcause_q[`FCE_BF_PUSH];
    endproperty
    a_push_exempt: assert property (p_push_exempt) else $error("entry push error escalated");

    property p_lock_enter;
        f_vld && to_hard && ctx_i.active == FC_HARD |=> lockup_o && !take_o.valid;
    endproperty
    a_lock_enter: assert property (p_lock_enter) else $error("no lockup on nested hard fault");

    property p_lock_stay;
        lockup_o |=> lockup_o [*8];
    endproperty
    a_lock_stay: assert property (p_lock_stay) else $error("lockup released without reset");

    property p_lock_quiet;
        lockup_o |-> ##1 !take_o.valid;
    endproperty
    a_lock_quiet: assert property (p_lock_quiet) else $error("fault taken while locked");

    property p_flag_hold;
        hcause_q[`FCE_HF_ESC] && !(w_hc && hwdata_i[`FCE_HF_ESC])
            |=> hcause_q[`FCE_HF_ESC];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("cause flag dropped");

    property p_baddr;
        f_vld && k == FK_BUS_EXACT |=> baddr_q == $past(fault_i.addr)
            && bcause_q[`FCE_BF_AVALID];
    endproperty
    a_baddr: assert property (p_baddr) else $error("bus address not captured");

    property p_hf_no_preempt_nmi;
        take_o.valid && take_o.cls == FC_HARD && $past(ctx_i.active) == FC_NMI
            |-> !take_o.preempt;
    endproperty
    a_hf_no_preempt_nmi: assert property (p_hf_no_preempt_nmi) else $error("hard fault preempted NMI");

    property p_ahb_wait;
        accept |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_ahb_wait: assert property (p_ahb_wait) else $error("bus answer timing wrong");

    c_escalate: cover property (f_vld && esc);
    c_lockup:   cover property (!lockup_o ##1 lockup_o);
    c_clear:    cover property (w_bc && |bcause_q);
    c_exempt:   cover property (f_vld && push_exempt);
endmodule
`default_nettype wire

// File: verilog/fce_cfg.svh
// Function
// - Bus, internal and no-execute errors raise faults
// - Vector read bus error is hard fault
// - Escalation takes hard fault, sets escalated flag
// - Five bus error kinds, own flag each
// - Coprocessor access, undefined op: usage faults
// - Foreign instruction set: usage fault, flag
// - Unaligned, bad return, divide zero: usage
// - Configurable fault priorities; hard fault fixed
// - Software disables configurable fault handlers
// - Normal entry decided by priority and mask; no mask here, entry uses priority and active class only
// - Same-kind fault in handler escalates
// - Equal or lower priority fault in handler escalates
// - Fault with disabled handler escalates
// - Push error entering bus handler never escalates
// - Only reset, NMI preempt hard fault
// - Hard fault preempts all but reset, NMI, itself
// - Each class has its own cause register
// - Precise bus and data access memory faults capture address
// - Hard fault inside hard handler locks up
// - Lockup halts instructions until reset
`ifndef FCE_CFG_SVH
`define FCE_CFG_SVH

`define FCE_PRIO_W      8
`define FCE_OFF_HCAUSE  8'h00
`define FCE_OFF_MCAUSE  8'h04
`define FCE_OFF_BCAUSE  8'h08
`define FCE_OFF_UCAUSE  8'h0C
`define FCE_OFF_MADDR   8'h10
`define FCE_OFF_BADDR   8'h14
`define FCE_OFF_ENABLE  8'h18
`define FCE_OFF_PRIO    8'h1C
`define FCE_OFF_STATUS  8'h20

`define FCE_HF_VECT     1
`define FCE_HF_ESC      30
`define FCE_MM_IACC     0
`define FCE_MM_DACC     1
`define FCE_MM_AVALID   7
`define FCE_BF_FETCH    0
`define FCE_BF_EXACT    1
`define FCE_BF_DEFER    2
`define FCE_BF_POP      3
`define FCE_BF_PUSH     4
`define FCE_BF_AVALID   7
`define FCE_UF_UNDEF    0
`define FCE_UF_ISA      1
`define FCE_UF_RET      2
`define FCE_UF_NO_COPROC_FLAG     3
`define FCE_UF_UNAL     8
`define FCE_UF_DIV0     9

`define FCE_EN_MM       0
`define FCE_EN_BUS      1
`define FCE_EN_USG      2
`define FCE_ENABLE_RST  32'h0000_0000
`define FCE_PRIO_RST    32'h0000_0000

`endif

// File: verilog/fce_pkg.sv
`default_nettype none
package fce_pkg;
    typedef enum logic [3:0] {
        FK_VECT, FK_BUS_PUSH, FK_BUS_POP, FK_BUS_FETCH,
        FK_BUS_EXACT, FK_BUS_DEFER, FK_MM_XN, FK_MM_DATA,
        FK_NO_COPROC_FLAG, FK_UNDEF, FK_ISA, FK_RETURN,
        FK_UNALIGN, FK_DIV0
    } fce_kind_e;

    typedef enum logic [2:0] {
        FC_NONE, FC_HARD, FC_MM, FC_BUS, FC_USAGE, FC_NMI, FC_OTHER
    } fce_class_e;

    typedef struct packed {
        logic        valid;
        fce_kind_e   kind;
        logic [31:0] addr;
    } fce_fault_s;

    typedef struct packed {
        logic       in_handler;
        fce_class_e active;
        logic [7:0] cur_prio;
        logic       bus_entry;
    } fce_ctx_s;

    typedef struct packed {
        logic       valid;
        fce_class_e cls;
        logic       escalated;
        logic       preempt;
    } fce_take_s;
endpackage
`default_nettype wire

// File: dv/fce_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
module fce_pipe_model (
    // Clock
    input  wire logic                core_clk_i,
    // Fault reports and context towards the block
    output var  fce_pkg::fce_fault_s fault_o,
    output var  fce_pkg::fce_ctx_s   ctx_o
);
    import fce_pkg::*;

    initial begin
        fault_o = '0;
        ctx_o   = '0;
    end

    // -------------------------------------------
    // One-cycle fault pulse, context steady with it
    // -------------------------------------------
    task automatic issue(input fce_kind_e k, input logic [31:0] a, input fce_ctx_s c);
        @(posedge core_clk_i);
        fault_o <= '{valid: 1'b1, kind: k, addr: a};
        ctx_o   <= c;
        @(posedge core_clk_i);
        fault_o.valid <= 1'b0;
        // Stale address must not look valid
        fault_o.addr  <= ~a;
    endtask
endmodule
`default_nettype wire

// File: dv/fault_classify_escalate_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fce_cfg.svh"
module fault_classify_escalate_tb;
    import fce_pkg::*;

    logic        core_clk, resetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, v, addr, prio;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        lockup, hreadyout, hresp, esc, pre;
    logic [7:0]  off, cur;
    fce_take_s   take;
    fce_fault_s  fault;
    fce_ctx_s    ctx;
    fce_class_e  c;
    fce_kind_e   kd;
    int          error_cnt, check_count, b, k, p, i;
    int          seed = 32'hee60b271;

    fce_fault_classify_escalate fce_fault_classify_escalate_i (
        .core_clk_i(core_clk), .resetn_i(resetn), .fault_i(fault), .ctx_i(ctx),
        .take_o(take), .lockup_o(lockup), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hreadyout), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp));
    fce_pipe_model fce_pipe_model_i (.core_clk_i(core_clk), .fault_o(fault), .ctx_o(ctx));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // -------------------------------------------
    // Reporting
    // -------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // -------------------------------------------
    // AHB-Lite single word transfers
    // -------------------------------------------
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'h0000_0000);
        if (n >= 40) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rst(input int n);
        resetn <= 1'b0;
        repeat (n) @(posedge core_clk);
        resetn <= 1'b1;
    endtask

    // -------------------------------------------
    // Expected classification
    // -------------------------------------------
    function automatic void kinfo(input fce_kind_e kk, output logic [7:0] o, output int bt, output fce_class_e cl);
        case (kk)
            FK_VECT:      begin o = `FCE_OFF_HCAUSE; bt = `FCE_HF_VECT;  cl = FC_HARD;  end
            FK_BUS_PUSH:  begin o = `FCE_OFF_BCAUSE; bt = `FCE_BF_PUSH;  cl = FC_BUS;   end
            FK_BUS_POP:   begin o = `FCE_OFF_BCAUSE; bt = `FCE_BF_POP;   cl = FC_BUS;   end
            FK_BUS_FETCH: begin o = `FCE_OFF_BCAUSE; bt = `FCE_BF_FETCH; cl = FC_BUS;   end
            FK_BUS_EXACT: begin o = `FCE_OFF_BCAUSE; bt = `FCE_BF_EXACT; cl = FC_BUS;   end
            FK_BUS_DEFER: begin o = `FCE_OFF_BCAUSE; bt = `FCE_BF_DEFER; cl = FC_BUS;   end
            FK_MM_XN:     begin o = `FCE_OFF_MCAUSE; bt = `FCE_MM_IACC;  cl = FC_MM;    end
            FK_MM_DATA:   begin o = `FCE_OFF_MCAUSE; bt = `FCE_MM_DACC;  cl = FC_MM;    end
            FK_NO_COPROC_FLAG:      begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_NO_COPROC_FLAG;  cl = FC_USAGE; end
            FK_UNDEF:     begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_UNDEF; cl = FC_USAGE; end
            FK_ISA:       begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_ISA;   cl = FC_USAGE; end
            FK_RETURN:    begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_RET;   cl = FC_USAGE; end
            FK_UNALIGN:   begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_UNAL;  cl = FC_USAGE; end
            default:      begin o = `FCE_OFF_UCAUSE; bt = `FCE_UF_DIV0;  cl = FC_USAGE; end
        endcase
    endfunction

    function automatic logic [7:0] pf(input fce_class_e cl, input logic [31:0] pr);
        return (cl == FC_MM) ? pr[7:0] : (cl == FC_BUS) ? pr[15:8] : (cl == FC_USAGE) ? pr[23:16] : 8'h00;
    endfunction

    // Preempt check skipped when epre is x
    task automatic hcase(input fce_kind_e kk, input fce_class_e act, input logic [7:0] cp, input logic be,
                         input fce_class_e ecl, input logic ee, input logic epre);
        fce_pipe_model_i.issue(kk, 32'h0000_0000, '{in_handler: 1'b1, active: act, cur_prio: cp, bus_entry: be});
        @(posedge core_clk);
        chk("take_cls", 32'({take.valid, take.cls, take.escalated}), 32'({1'b1, ecl, ee}));
        if (epre !== 1'bx) begin
            chk("take_pre", 32'(take.preempt), 32'(epre));
        end
    endtask

    // -------------------------------------------
    // Main sequence
    // -------------------------------------------
    initial begin
        error_cnt = 0;
        check_count = 0;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        rst(12);
        wr(8'h24, 32'hFFFF_FFFF);
        for (i = 0; i < 10; i++) begin
            ahb(1'b0, 8'(i * 4), 32'h0, v);
            chk("reset_reg", v, 32'h0000_0000);
        end
        // Disabled handlers first, then enabled with random priorities
        for (p = 0; p < 2; p++) begin
            prio = $random(seed);
            wr(`FCE_OFF_ENABLE, p ? 32'h0000_0007 : `FCE_ENABLE_RST);
            wr(`FCE_OFF_PRIO, prio);
            ahb(1'b0, `FCE_OFF_PRIO, 32'h0, v);
            chk("prio", v, prio & 32'h00FF_FFFF);
            for (k = 0; k < 14; k++) begin
                kd = fce_kind_e'(k);
                kinfo(kd, off, b, c);
                cur = $random(seed);
                addr = $random(seed);
                esc = (p == 0) && (c != FC_HARD);
                pre = (c == FC_HARD) || esc || (pf(c, prio) < cur);
                fce_pipe_model_i.issue(kd, addr, '{in_handler: 1'b0, active: FC_NONE, cur_prio: cur, bus_entry: 1'b0});
                @(posedge core_clk);
                chk("take", 32'(take), 32'({1'b1, esc ? FC_HARD : c, esc, pre}));
                wr(off, 32'h0000_0000);
                ahb(1'b0, off, 32'h0, v);
                chk("cause", 32'(v[b]), 32'h1);
                ahb(1'b0, `FCE_OFF_HCAUSE, 32'h0, v);
                chk("esc_flag", 32'(v[`FCE_HF_ESC]), 32'(esc));
                if (kd == FK_BUS_EXACT || kd == FK_MM_DATA) begin
                    ahb(1'b0, (kd == FK_BUS_EXACT) ? `FCE_OFF_BADDR : `FCE_OFF_MADDR, 32'h0, v);
                    chk("fault_addr", v, addr);
                end
                wr(off, 32'hFFFF_FFFF);
                wr(`FCE_OFF_HCAUSE, 32'hFFFF_FFFF);
                ahb(1'b0, off, 32'h0, v);
                chk("cleared", v, 32'h0000_0000);
            end
        end
        wr(`FCE_OFF_PRIO, 32'h0010_2030);
        hcase(FK_UNDEF, FC_USAGE, 8'h80, 1'b0, FC_HARD, 1'b1, 1'b1);
        hcase(FK_NO_COPROC_FLAG, FC_OTHER, 8'h10, 1'b0, FC_HARD, 1'b1, 1'b1);
        hcase(FK_BUS_FETCH, FC_MM, 8'h30, 1'b0, FC_BUS, 1'b0, 1'b1);
        hcase(FK_BUS_PUSH, FC_BUS, 8'h20, 1'b1, FC_BUS, 1'b0, 1'bx);
        hcase(FK_VECT, FC_NMI, 8'h00, 1'b0, FC_HARD, 1'b0, 1'b0);
        hcase(FK_VECT, FC_USAGE, 8'h00, 1'b0, FC_HARD, 1'b0, 1'b1);
        wr(`FCE_OFF_UCAUSE, 32'hFFFF_FFFF);
        fce_pipe_model_i.issue(FK_VECT, 32'h0, '{in_handler: 1'b1, active: FC_HARD, cur_prio: 8'h00, bus_entry: 1'b0});
        @(posedge core_clk);
        chk("lock_enter", 32'({lockup, take.valid}), 32'h2);
        fce_pipe_model_i.issue(FK_UNDEF, 32'h0, '{in_handler: 1'b0, active: FC_NONE, cur_prio: 8'hFF, bus_entry: 1'b0});
        @(posedge core_clk);
        chk("lock_take", 32'(take.valid), 32'h0);
        ahb(1'b0, `FCE_OFF_UCAUSE, 32'h0, v);
        chk("lock_ucause", v, 32'h0000_0000);
        ahb(1'b0, `FCE_OFF_STATUS, 32'h0, v);
        chk("lock_status", 32'(v[0]), 32'h1);
        rst(2);
        @(posedge core_clk);
        chk("lock_reset", 32'(lockup), 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
